// >>> hdl/muldiv_mode_status_control.v
// Mode, status and result-flag logic of a multiplier/divider coprocessor.
//
// Operation
// RULE_01: Carry flag on carry or zero divisor.
// RULE_02: Zero flag follows zero result, writable.
// RULE_03: Negative flag; accumulate mirrors result top bit.
// RULE_04: Overflow flag on two's complement range excess.
// RULE_05: Saturation flag sticky, cleared by writing zero.
// RULE_06: Busy bit high while computing, resets low.
// RULE_07: Run permit gates starts, current one finishes.
// RULE_08: Sign bit selects unsigned or signed arithmetic.
// RULE_09: Three-bit function code selects the operation.
// RULE_10: Software loads control byte per function table.
// RULE_11: Byte registers reachable through wider accesses.
// RULE_12: Unaffected flags keep their previous value.
// RULE_13: Saturating accumulate updates all five flags.
// RULE_14: Writing top operand byte starts the computation.
// RULE_15: Saturating accumulate clamps to extreme values.
// RULE_16: Signed mode treats top bits as signs.
// RULE_17: Unassigned bits read zero, ignore writes.
// RULE_18: Busy bit ignores software writes.
`timescale 1ns/1ps
`include "muldiv_consts.vh"
`default_nettype none

module muldiv_mode_status_control (
	input wire clk_i, // System clock, 25 MHz.
	input wire rst_n_i, // Asynchronous reset, active low.
	input wire [3:0] avs_address_i, // Byte address of the word.
	input wire avs_read_i, // Read request.
	input wire avs_write_i, // Write request.
	input wire [31:0] avs_writedata_i, // Write data.
	input wire [3:0] avs_byteenable_i, // Byte lanes of a write.
	output reg [31:0] avs_readdata_o, // Read data.
	output wire avs_waitrequest_o, // Stall of the current request.
	output reg busy_o // Computation in progress.
);

	// Merges enabled byte lanes of new data into an old word.
	function [31:0] merge_bytes;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] lanes;
		integer i;
		begin
			merge_bytes = old_word;
			for (i = 0; i < 4; i = i + 1) begin
				if (lanes[i]) begin
					merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
				end
			end
		end
	endfunction

	// Flags that a function and signedness combination updates.
	function [4:0] flag_mask;
		input [2:0] mode;
		input signed_mode;
		begin
			case (mode)
				`MD_MODE_MUL: flag_mask = signed_mode ?
					`MD_MASK_MUL_S : `MD_MASK_MUL_U;
				`MD_MODE_DIV16: flag_mask = signed_mode ?
					`MD_MASK_DIV16_S : `MD_MASK_DIV_U;
				`MD_MODE_DIV32: flag_mask = signed_mode ?
					`MD_MASK_DIV32_S : `MD_MASK_DIV_U;
				`MD_MODE_MAC: flag_mask = `MD_MASK_MAC;
				`MD_MODE_MACSAT: flag_mask = `MD_MASK_MACSAT;
				default: flag_mask = `MD_MASK_NONE;
			endcase
		end
	endfunction

	reg run_permit;
	reg sign_sel;
	reg [2:0] mode_sel;
	reg [4:0] flags;
	reg [31:0] op_lo;
	reg [31:0] op_hi;
	reg [2:0] calc_cnt;
	reg [2:0] run_mode;
	reg run_sign;
	reg ack;

	// Bus decode.
	wire req = avs_read_i | avs_write_i;
	wire hit_ctrl = (avs_address_i == `MD_ADDR_CTRL);
	wire hit_lo = (avs_address_i == `MD_ADDR_OPLO);
	wire hit_hi = (avs_address_i == `MD_ADDR_OPHI);
	// Operand writes wait out a computation so its inputs stay stable.
	wire stall = avs_write_i & (hit_lo | hit_hi) & busy_o;
	wire wr_now = avs_write_i & ack;
	wire start = wr_now & hit_hi & avs_byteenable_i[3] & run_permit &
		(flag_mask(mode_sel, sign_sel) != `MD_MASK_NONE); // [RULE_14] [RULE_07] [RULE_09]
	wire commit = (calc_cnt == `MD_CNT_LAST);

	assign avs_waitrequest_o = req & ~ack;

	// Multiply core, sign chosen by the latched mode.
	wire [15:0] mcand = op_hi[31:16];
	wire [15:0] mplier = op_hi[15:0];
	wire [31:0] prod_s = $signed(mcand) * $signed(mplier); // [RULE_16]
	wire [31:0] prod_u = mcand * mplier;
	wire [31:0] prod = run_sign ? prod_s : prod_u; // [RULE_08]

	// Accumulate in 34 bits so both carry and signed range are visible.
	wire [33:0] acc_u = {2'b00, prod} + {2'b00, op_lo};
	wire [33:0] acc_s = {{2{prod[31]}}, prod} + {{2{op_lo[31]}}, op_lo};
	wire acc_range = run_sign ? (acc_s[32] != acc_s[31]) : acc_u[32]; // [RULE_04]
	reg [31:0] acc_res;

	// Divider works on magnitudes; signs are restored afterwards.
	wire [31:0] dvsr = (run_mode == `MD_MODE_DIV16) ?
		{{16{run_sign & op_hi[31]}}, op_hi[31:16]} : op_hi;
	wire dvd_neg = run_sign & op_lo[31]; // [RULE_16]
	wire dvs_neg = run_sign & dvsr[31];
	wire [31:0] dvd_mag = dvd_neg ? (`MD_RST_WORD - op_lo) : op_lo;
	wire [31:0] dvs_mag = dvs_neg ? (`MD_RST_WORD - dvsr) : dvsr;
	wire div_zero = (dvsr == `MD_RST_WORD);
	// A zero divisor is replaced so the divider never sees it.
	wire [31:0] dvs_safe = div_zero ? `MD_ONE : dvs_mag;
	wire [31:0] q_mag = dvd_mag / dvs_safe;
	wire [31:0] r_mag = dvd_mag % dvs_safe;
	wire [31:0] quot = div_zero ? `MD_ALL_ONES :
		((dvd_neg ^ dvs_neg) ? (`MD_RST_WORD - q_mag) : q_mag);
	wire [31:0] rem = div_zero ? op_lo :
		(dvd_neg ? (`MD_RST_WORD - r_mag) : r_mag);
	wire div_range = run_sign & ~div_zero & (op_lo == `MD_SAT_NEG) &
		(dvsr == `MD_ALL_ONES); // [RULE_04]

	reg [4:0] new_flags;
	reg sat_hit;
	// Result and new flag values of the latched function.
	always @* begin
		new_flags = `MD_RST_FLAGS;
		sat_hit = 1'b0;
		acc_res = run_sign ? acc_s[31:0] : acc_u[31:0];
		case (run_mode)
			`MD_MODE_MUL: begin
				new_flags[`MD_F_Z] = (prod == `MD_RST_WORD); // [RULE_02]
				new_flags[`MD_F_S] = prod[31]; // [RULE_03]
			end
			`MD_MODE_DIV16, `MD_MODE_DIV32: begin
				new_flags[`MD_F_C] = div_zero; // [RULE_01]
				new_flags[`MD_F_Z] = (quot == `MD_RST_WORD); // [RULE_02]
				new_flags[`MD_F_S] = quot[31]; // [RULE_03]
				new_flags[`MD_F_V] = div_range; // [RULE_04]
			end
			`MD_MODE_MAC, `MD_MODE_MACSAT: begin
				if (run_mode == `MD_MODE_MACSAT && acc_range) begin
					sat_hit = 1'b1; // [RULE_05]
					// Unsigned excess can only be positive.
					if (!run_sign) begin
						acc_res = `MD_ALL_ONES;
					end else if (acc_s[33]) begin
						acc_res = `MD_SAT_NEG; // [RULE_15]
					end else begin
						acc_res = `MD_SAT_POS; // [RULE_15]
					end
				end
				new_flags[`MD_F_C] = acc_u[32]; // [RULE_01]
				new_flags[`MD_F_Z] = (acc_res == `MD_RST_WORD); // [RULE_02]
				new_flags[`MD_F_S] = acc_res[31]; // [RULE_03]
				new_flags[`MD_F_V] = acc_range; // [RULE_04] [RULE_13]
				new_flags[`MD_F_Q] = sat_hit; // [RULE_13]
			end
			default: begin
				new_flags = `MD_RST_FLAGS;
			end
		endcase
	end

	// Bus handshake: one wait cycle after any stall of an operand write, then the answer with registered data.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack <= 1'b0;
			avs_readdata_o <= `MD_RST_WORD;
		end else begin
			ack <= req & ~ack & ~stall;
			if (avs_read_i & ~ack) begin
				avs_readdata_o <= `MD_RST_WORD; // [RULE_17]
				if (hit_ctrl) begin
					avs_readdata_o[`MD_CTL_RUN] <= run_permit;
					avs_readdata_o[`MD_CTL_SIGN] <= sign_sel;
					avs_readdata_o[`MD_CTL_MODE_HI:0] <= mode_sel;
					avs_readdata_o[`MD_FLG_CARRY:`MD_FLG_SAT] <= flags; // [RULE_11]
					avs_readdata_o[`MD_FLG_BUSY] <= busy_o; // [RULE_06]
				end else if (hit_lo) begin
					avs_readdata_o <= op_lo;
				end else if (hit_hi) begin
					avs_readdata_o <= op_hi;
				end
			end
		end
	end

	// Control byte: software owned, may change while busy.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_permit <= 1'b0;
			sign_sel <= 1'b0;
			mode_sel <= `MD_MODE_MUL;
		end else if (wr_now & hit_ctrl & avs_byteenable_i[0]) begin
			run_permit <= avs_writedata_i[`MD_CTL_RUN]; // [RULE_07]
			sign_sel <= avs_writedata_i[`MD_CTL_SIGN]; // [RULE_08]
			mode_sel <= avs_writedata_i[`MD_CTL_MODE_HI:0]; // [RULE_09]
		end
	end

	// Computation sequencer; mode is latched so control writes made
	// during a run cannot disturb it.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			calc_cnt <= `MD_CNT_ZERO;
			busy_o <= 1'b0;
			run_mode <= `MD_MODE_MUL;
			run_sign <= 1'b0;
		end else if (start) begin
			calc_cnt <= `MD_CALC_CYCLES;
			busy_o <= 1'b1; // [RULE_06] [RULE_18]
			run_mode <= mode_sel;
			run_sign <= sign_sel;
		end else if (calc_cnt != `MD_CNT_ZERO) begin
			calc_cnt <= calc_cnt - `MD_CNT_LAST;
			busy_o <= ~commit; // [RULE_07]
		end
	end

	wire [4:0] upd_mask = flag_mask(run_mode, run_sign);
	wire flag_wr = wr_now & hit_ctrl & avs_byteenable_i[1];
	reg [4:0] next_flags;
	// Software writes first, then the finishing computation wins.
	always @* begin
		next_flags = flags;
		if (flag_wr) begin
			next_flags[4:1] = avs_writedata_i[`MD_FLG_CARRY:`MD_FLG_RANGE];
			if (!avs_writedata_i[`MD_FLG_SAT]) begin
				next_flags[`MD_F_Q] = 1'b0; // [RULE_05]
			end
		end
		if (commit) begin
			next_flags[4:1] = (next_flags[4:1] & ~upd_mask[4:1]) |
				(new_flags[4:1] & upd_mask[4:1]); // [RULE_12]
			if (upd_mask[`MD_F_Q] & sat_hit) begin
				next_flags[`MD_F_Q] = 1'b1; // [RULE_05] [RULE_13]
			end
		end
	end

	// Flag register.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags <= `MD_RST_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end

	// Operand and result words; results land where each function puts
	// them, other bytes keep their previous contents.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_lo <= `MD_RST_WORD;
			op_hi <= `MD_RST_WORD;
		end else if (commit) begin
			case (run_mode)
				`MD_MODE_MUL: op_lo <= prod;
				`MD_MODE_DIV16: begin
					op_lo <= quot;
					op_hi[15:0] <= rem[15:0];
				end
				`MD_MODE_DIV32: begin
					op_lo <= quot;
					op_hi <= rem;
				end
				`MD_MODE_MAC, `MD_MODE_MACSAT: op_lo <= acc_res;
				default: op_lo <= op_lo;
			endcase
		end else if (wr_now & hit_lo) begin
			op_lo <= merge_bytes(op_lo, avs_writedata_i, avs_byteenable_i); // [RULE_11]
		end else if (wr_now & hit_hi) begin
			op_hi <= merge_bytes(op_hi, avs_writedata_i, avs_byteenable_i); // [RULE_11]
		end
	end

endmodule // muldiv_mode_status_control

`default_nettype wire

// >>> hdl/muldiv_consts.vh
// Constants for the multiplier/divider mode, status and control block.
`ifndef MULDIV_CONSTS_VH
`define MULDIV_CONSTS_VH
// Byte addresses of the register words on the bus.
`define MD_ADDR_CTRL 4'h0
`define MD_ADDR_OPLO 4'h8
`define MD_ADDR_OPHI 4'hc
// Bit positions inside the control byte.
`define MD_CTL_RUN 7
`define MD_CTL_SIGN 4
`define MD_CTL_MODE_HI 2
// Bit positions of the flags inside the 16-bit word view.
`define MD_FLG_CARRY 15
`define MD_FLG_ZERO 14
`define MD_FLG_NEG 13
`define MD_FLG_RANGE 12
`define MD_FLG_SAT 11
`define MD_FLG_BUSY 8
// Positions inside the internal five-bit flag vector.
`define MD_F_C 4
`define MD_F_Z 3
`define MD_F_S 2
`define MD_F_V 1
`define MD_F_Q 0
// Function codes.
`define MD_MODE_MUL 3'h0
`define MD_MODE_DIV16 3'h1
`define MD_MODE_MAC 3'h2
`define MD_MODE_MACSAT 3'h3
`define MD_MODE_DIV32 3'h5
// Flags touched by each function, ordered c z s ov q.
`define MD_MASK_NONE 5'h00
`define MD_MASK_MUL_S 5'h0c
`define MD_MASK_MUL_U 5'h08
`define MD_MASK_DIV16_S 5'h1e
`define MD_MASK_DIV32_S 5'h1c
`define MD_MASK_DIV_U 5'h18
`define MD_MASK_MAC 5'h1e
`define MD_MASK_MACSAT 5'h1f
// Reset values and fixed data values.
`define MD_RST_CTRL 5'h00
`define MD_RST_FLAGS 5'h00
`define MD_RST_WORD 32'h00000000
`define MD_SAT_POS 32'h7fffffff
`define MD_SAT_NEG 32'h80000000
`define MD_ALL_ONES 32'hffffffff
`define MD_ONE 32'h00000001
// Cycles that one computation keeps the unit busy.
`define MD_CALC_CYCLES 3'h4
`define MD_CNT_ZERO 3'h0
`define MD_CNT_LAST 3'h1
`endif

// >>> tb/md_chk.sv
// Checker of bus timing, busy span and fixed read values.
`timescale 1ns/1ps
`default_nettype none
module md_chk (
	input wire logic clk_i, // Clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire logic [3:0] avs_address_i, // Byte address of the word.
	input wire logic avs_read_i, // Read.
	input wire logic avs_write_i, // Write.
	input wire logic [31:0] avs_writedata_i, // Write data.
	input wire logic [3:0] avs_byteenable_i, // Lanes.
	input wire logic [31:0] avs_readdata_o, // Read data.
	input wire logic avs_waitrequest_o, // Stall.
	input wire logic busy_o // Busy.
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// A read is answered when waitrequest is low with read high.
	wire rd_ok = avs_read_i && !avs_waitrequest_o;
	a_busy_span: assert property ($rose(busy_o) |-> busy_o[*4] ##1 !busy_o)
		else $error("busy span is not four cycles");
	a_start_cause: assert property ($rose(busy_o) |-> $past(avs_write_i && !avs_waitrequest_o && avs_address_i == 4'hc && avs_byteenable_i[3]))
		else $error("busy rose without a top operand write");
	a_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read not answered after one wait cycle");
	a_idle_nowait: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
		else $error("waitrequest high with no request");
	a_stall_bound: assert property (avs_write_i && avs_waitrequest_o |-> ##[1:6] !avs_waitrequest_o)
		else $error("write stalled too long");
	a_reserved_zero: assert property (rd_ok && avs_address_i == 4'h0 |-> avs_readdata_o[31:16] == 16'h0000 && avs_readdata_o[10:9] == 2'h0 && avs_readdata_o[6:5] == 2'h0 && !avs_readdata_o[3])
		else $error("unassigned bits not zero");
	a_unmapped_zero: assert property (rd_ok && avs_address_i == 4'h4 |-> avs_readdata_o == 32'h00000000)
		else $error("unmapped read not zero");
	a_data_holds: assert property ($changed(avs_readdata_o) |-> rd_ok)
		else $error("read data moved outside an answer");
	c_start: cover property ($rose(busy_o));
	c_stall: cover property (avs_write_i && avs_waitrequest_o && busy_o);
	c_unmapped: cover property (rd_ok && avs_address_i == 4'h4);
endmodule // md_chk
`default_nettype wire

// >>> tb/md_master.sv
// Bus master model of the processor core reaching the registers.
`timescale 1ns/1ps
`default_nettype none
module md_master (
	input wire logic clk_i, // Clock.
	input wire logic waitrequest_i, // Slave stall.
	input wire logic [31:0] readdata_i, // Read data.
	output logic [3:0] address_o, // Byte address of the word.
	output logic read_o, // Read request.
	output logic write_o, // Write request.
	output logic [31:0] writedata_o, // Write data.
	output logic [3:0] byteenable_o // Write lanes.
);
	// Idle bus at time zero.
	initial begin
		{address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
	end
	// Released lines show inverted data so stale values cannot pass.
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		address_o <= a;
		writedata_o <= d;
		byteenable_o <= be;
		write_o <= 1'b1;
		// Waitrequest is sampled at the rising edge that ends the write.
		do @(posedge clk_i); while (waitrequest_i);
		write_o <= 1'b0;
		writedata_o <= ~d;
		address_o <= ~a;
		@(posedge clk_i);
	endtask
	// Read data are taken at the answering edge, then the bus is released.
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		address_o <= a;
		read_o <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i);
		d = readdata_i;
		read_o <= 1'b0;
		address_o <= ~a;
		@(posedge clk_i);
	endtask
endmodule // md_master
`default_nettype wire

// >>> tb/muldiv_mode_status_control_tb.sv
// Self-checking bench of the mode, status and flag block.
`timescale 1ns/1ps
`default_nettype none
module muldiv_mode_status_control_tb;
	logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o;
	logic [3:0] avs_address_i, avs_byteenable_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rdat, a, b;
	logic [7:0] m_ctrl, m_flags; // Model of the two byte registers.
	int n_errors, total_checks, seed;
	muldiv_mode_status_control u_dut (.clk_i, .rst_n_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
		.avs_readdata_o, .avs_waitrequest_o, .busy_o);
	md_master u_cpu (.clk_i(clk_i), .waitrequest_i(avs_waitrequest_o),
		.readdata_i(avs_readdata_o), .address_o(avs_address_i),
		.read_o(avs_read_i), .write_o(avs_write_i),
		.writedata_o(avs_writedata_i), .byteenable_o(avs_byteenable_i));
	// Clock of 40 ns.
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One computation; only flags in the mask follow the result.
	task automatic run(input logic [7:0] ctl, input logic [31:0] lo, hi,
		input logic [4:0] mask, fl, input logic [31:0] res);
		logic go;
		go = ctl[7] && ctl[2:0] != 3'h4 && ctl[2:0] < 3'h6;
		u_cpu.wr(4'h0, {24'h0, ctl}, 4'h1);
		u_cpu.wr(4'h8, lo, 4'hf);
		u_cpu.wr(4'hc, hi, 4'hf);
		@(negedge clk_i);
		check("busy", busy_o, go);
		repeat (5) @(posedge clk_i);
		m_ctrl = ctl & 8'h97;
		// Saturation is sticky: a run may set it but never clears it.
		m_flags = (m_flags & ~{mask[4:1], 4'h0}) |
			({fl[4:1], 4'h0} & {mask[4:1], 4'h0}) |
			{4'h0, fl[0] & mask[0], 3'h0};
		u_cpu.rd(4'h8, rdat);
		check("result", rdat, res);
		u_cpu.rd(4'h0, rdat);
		check("flags", rdat, {16'h0, m_flags, m_ctrl});
	endtask
	// Main sequence.
	initial begin
		seed = 67;
		n_errors = 0;
		total_checks = 0;
		m_flags = 8'h00;
		rst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		u_cpu.rd(4'h0, rdat);
		check("reset", rdat, 32'h0);
		// Random writes: reserved, busy and set of saturation are dropped.
		repeat (4) begin
			a = $random(seed);
			u_cpu.wr(4'h0, a, 4'h3);
			u_cpu.rd(4'h0, rdat);
			check("ctrl", rdat, {16'h0, a[15:12], 4'h0, a[7:0] & 8'h97});
		end
		u_cpu.wr(4'h4, a, 4'hf);
		u_cpu.rd(4'h4, rdat);
		check("unmapped", rdat, 32'h0);
		u_cpu.wr(4'h0, 32'h8000, 4'h2);
		m_flags = 8'h80;
		run(8'h80, 32'h0, 32'h1234, 5'h08, 5'h08, 32'h0);
		a = $random(seed);
		b = a[31:16] * a[15:0];
		run(8'h80, 32'h0, a, 5'h08, {1'b0, b == 0, 3'h0}, b);
		run(8'h90, 32'h0, 32'hffff0002, 5'h0c, 5'h04, 32'hfffffffe);
		run(8'h81, 32'h1234, 32'h0, 5'h18, 5'h10, 32'hffffffff);
		run(8'h82, 32'hffffffff, 32'h10001, 5'h1e, 5'h1a, 32'h0);
		run(8'h93, 32'h7fff0000, 32'h7fff7fff, 5'h1f, 5'h03, 32'h7fffffff);
		run(8'h91, 32'h80000000, 32'hffff0000, 5'h1e, 5'h06,
			32'h80000000);
		run(8'h92, 32'h1, 32'hffff0001, 5'h1e, 5'h18, 32'h0);
		run(8'h83, 32'hffffffff, 32'h20003, 5'h1f, 5'h17,
			32'hffffffff);
		run(8'h93, 32'h80000000, 32'h7fff8000, 5'h1f, 5'h17,
			32'h80000000);
		run(8'h90, 32'h0, 32'h5, 5'h0c, 5'h08, 32'h0);
		run(8'h10, 32'h5, 32'h20002, 5'h0, 5'h0, 32'h5);
		run(8'h84, 32'h6, 32'h20002, 5'h0, 5'h0, 32'h6);
		u_cpu.wr(4'h0, 32'h0, 4'h2);
		m_flags = 8'h00;
		run(8'h85, 32'd100, 32'd7, 5'h18, 5'h00, 32'd14);
		// An operand write made while busy waits and lands after the result.
		u_cpu.wr(4'hc, 32'd7, 4'hf);
		u_cpu.wr(4'h8, 32'd50, 4'hf);
		u_cpu.rd(4'h8, rdat);
		check("stall", rdat, 32'd50);
		// Permit cleared mid-run: the run finishes, the next one is blocked.
		u_cpu.wr(4'hc, 32'd5, 4'hf);
		u_cpu.wr(4'h0, 32'h0, 4'h1);
		u_cpu.wr(4'hc, 32'd9, 4'hf);
		@(negedge clk_i);
		check("blocked", busy_o, 1'b0);
		@(posedge clk_i);
		u_cpu.rd(4'h8, rdat);
		check("finish", rdat, 32'd10);
		report_and_stop();
	end
	// Watchdog well beyond the expected run length.
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule // muldiv_mode_status_control_tb
bind muldiv_mode_status_control md_chk u_chk (.clk_i, .rst_n_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .busy_o);
`default_nettype wire
